// File: src/spcb_top.sv
// Serial port control, status and baud generator with a simple shifter
//
// Design decisions made here: the address map and strobed register access.
`include "spcb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module spcb_top
  import spcb_pkg::*;
#(
  parameter int ABD_MAX = 65535
) (
  input  wire logic       clk,       // System clock, 25 MHz
  input  wire logic       rst,       // Asynchronous reset, high
  input  wire logic [2:0] addr,      // Register index
  input  wire logic [7:0] wdata,     // Write data
  input  wire logic       wr,        // Write strobe
  input  wire logic       rd,        // Read strobe
  output logic      [7:0] rdata,     // Read data, cycle after rd
  input  wire logic       rxd_i,     // Receive/data pin level
  output logic            rxd_o,     // Data pin drive (sync transmit)
  output logic            rxd_oe_n,  // Data pin enable, low drives
  input  wire logic       ck_i,      // Transmit/clock pin level
  output logic            ck_o,      // Transmit/clock pin drive
  output logic            ck_oe_n,   // Clock pin enable, low drives
  output logic            rx_flag,   // Receive interrupt flag level
  output logic            baud_tick  // Baud timer tick pulse
);
  initial begin
    if (ABD_MAX < 2 || ABD_MAX > 65535) $error("ABD_MAX out of range");
  end

  typedef struct packed {
    logic [7:0] txc, rxc, bdc, dlo, dhi;
    logic [15:0] cnt;
    logic [7:0] pre;
    logic [2:0] rs;
    logic       rxl;
    spcb_st_e   rst_s;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic [7:0] rbuf;
    logic       rfull, rf9, rfe;
    spcb_tst_e  tst;
    logic [3:0] tbit;
    logic [9:0] tsh;
    logic [7:0] tbuf;
    logic       tfull, tbrk;
    logic       txo, cko, dto;
    logic [15:0] abdc;
    logic [1:0] abdst;
    logic [7:0] rdata;
    logic       flag, tick;
  } spcb_s;
  spcb_s q_r, q_nxt;

  logic sync_m, en, in_l, tick_p, rx_on;
  logic [15:0] div, mul_v;
  always_comb begin
    sync_m = q_r.txc[`B_SYNC];
    en     = q_r.rxc[`B_PORT_ENABLE];
    div = q_r.bdc[`B_WIDE] ? {q_r.dhi, q_r.dlo} : {8'h00, q_r.dlo};
    // multiplier choice; HIGH_SPEED_BAUD_SELECT ignored in sync
    if (sync_m) mul_v = {8'h00, `SPCB_MUL_SYN};
    else if (q_r.bdc[`B_WIDE])
      mul_v = {8'h00, q_r.txc[`B_HIGH_SPEED_BAUD_SELECT] ? `SPCB_MUL_A16H : `SPCB_MUL_A16L};
    else mul_v = {8'h00, q_r.txc[`B_HIGH_SPEED_BAUD_SELECT] ? `SPCB_MUL_A8H : `SPCB_MUL_A8L};
    in_l   = q_r.rxl ^ q_r.bdc[`B_RXP];
    tick_p = (q_r.pre == 8'(mul_v - 16'd1)) && (q_r.cnt == div);
    // continuous enable, or master single receive
    rx_on  = q_r.rxc[`B_CONTINUOUS_RECEIVE_ENABLE] || (sync_m && q_r.txc[`B_CLOCK_SOURCE_SELECT] && q_r.rxc[`B_SINGLE_RECEIVE_ENABLE]);
  end

  // Next state: registers, baud timer, receiver, transmitter
  always_comb begin
    q_nxt = q_r;
    q_nxt.tick = 1'b0;
    q_nxt.rdata = 8'h00;
    // Three-stage filter; change counts when stages two and three agree
    q_nxt.rs = {q_r.rs[1:0], rxd_i};
    if (q_r.rs[2] == q_r.rs[1]) q_nxt.rxl = q_r.rs[2];
    if (q_r.pre == 8'(mul_v - 16'd1)) begin
      q_nxt.pre = 8'h00;
      q_nxt.cnt = (q_r.cnt == div) ? 16'h0000 : q_r.cnt + 16'd1;
    end else q_nxt.pre = q_r.pre + 8'd1;
    if (tick_p) q_nxt.tick = 1'b1;
    // Register reads
    if (rd) begin
      case (addr)
        `SPCB_OFF_TXC: q_nxt.rdata = q_r.txc;
        `SPCB_OFF_RXC: q_nxt.rdata = q_r.rxc;
        `SPCB_OFF_BDC: q_nxt.rdata = q_r.bdc;
        `SPCB_OFF_DLO: q_nxt.rdata = q_r.dlo;
        `SPCB_OFF_DHI: q_nxt.rdata = q_r.dhi;
        `SPCB_OFF_RXB: begin
          q_nxt.rdata = q_r.rbuf;
          q_nxt.rfull = 1'b0;
        end
        default: q_nxt.rdata = 8'h00;
      endcase
    end
    // Register writes; status bits are masked
    if (wr) begin
      case (addr)
        `SPCB_OFF_TXC: q_nxt.txc = (wdata & `SPCB_TXC_WMASK) | (q_r.txc & ~`SPCB_TXC_WMASK);
        `SPCB_OFF_RXC: q_nxt.rxc = (wdata & `SPCB_RXC_WMASK) | (q_r.rxc & ~`SPCB_RXC_WMASK);
        `SPCB_OFF_BDC: q_nxt.bdc = (wdata & `SPCB_BDC_WMASK) | (q_r.bdc & ~`SPCB_BDC_WMASK);
        `SPCB_OFF_DLO: q_nxt.dlo = wdata;
        `SPCB_OFF_DHI: q_nxt.dhi = wdata;
        `SPCB_OFF_TXB: if (!q_r.tfull) begin
          q_nxt.tbuf = wdata;
          q_nxt.tfull = 1'b1;
        end
        default: ;
      endcase
      if (addr == `SPCB_OFF_DLO || addr == `SPCB_OFF_DHI) begin
        q_nxt.cnt = 16'h0000;
        q_nxt.pre = 8'h00;
      end
    end
    q_nxt.flag = q_r.rfull;
    // wake-up: falling edge flags, rising edge clears
    if (!sync_m && q_r.bdc[`B_WUE]) begin
      if (q_r.rs[2] != q_r.rxl && q_r.rs[1] == q_r.rs[2]) begin
        if (!(q_r.rs[2] ^ q_r.bdc[`B_RXP])) q_nxt.flag = 1'b1;
        else q_nxt.bdc[`B_WUE] = 1'b0;
      end
    end
    // auto-baud: time a low pulse of the start bit
    else if (!sync_m && q_r.bdc[`B_ABD]) begin
      case (q_r.abdst)
        2'd0: if (!in_l) begin
          q_nxt.abdst = 2'd1;
          q_nxt.abdc = 16'h0000;
        end
        2'd1: begin
          if (q_r.abdc == 16'(ABD_MAX)) begin
            q_nxt.bdc[`B_ABOV] = 1'b1;
            q_nxt.abdst = 2'd2;
          end else q_nxt.abdc = q_r.abdc + 16'd1;
          if (in_l) begin
            q_nxt.dlo = q_r.abdc[7:0];
            q_nxt.dhi = q_r.abdc[15:8];
            q_nxt.abdst = 2'd2;
          end
        end
        default: begin
          q_nxt.bdc[`B_ABD] = 1'b0;
          q_nxt.abdst = 2'd0;
        end
      endcase
    end
    // Receiver, advanced on baud ticks
    else if (rx_on && tick_p) begin
      case (q_r.rst_s)
        SPCB_IDLE: if (!in_l) begin
          // Start already sampled on this tick; the next tick lands in data bit 0
          q_nxt.rst_s = SPCB_DATA;
          q_nxt.rbit = 4'h0;
          q_nxt.bdc[`B_IDLE] = sync_m ? q_r.bdc[`B_IDLE] : 1'b0;
        end
        SPCB_START: q_nxt.rst_s = SPCB_DATA;
        SPCB_DATA: begin
          q_nxt.rsh = {in_l, q_r.rsh[8:1]};
          q_nxt.rbit = q_r.rbit + 4'h1;
          if (q_r.rbit == (q_r.rxc[`B_RX9] ? 4'h8 : 4'h7)) q_nxt.rst_s = SPCB_STOP;
        end
        default: begin
          q_nxt.rst_s = SPCB_IDLE;
          q_nxt.bdc[`B_IDLE] = 1'b1;
          if (!(q_r.rxc[`B_RX9] && q_r.rxc[`B_ADEN] && !sync_m) || q_r.rsh[8]) begin
            if (q_r.rfull) q_nxt.rxc[`B_OVERRUN_ERROR_FLAG] = 1'b1;
            else begin
              q_nxt.rfull = 1'b1;
              q_nxt.rbuf = q_r.rxc[`B_RX9] ? q_r.rsh[7:0] : q_r.rsh[8:1];
              q_nxt.rxc[`B_NINTH_RECEIVE_BIT] = q_r.rxc[`B_RX9] ? q_r.rsh[8] : 1'b0;
              q_nxt.rxc[`B_FRAMING_ERROR_FLAG] = !sync_m && !in_l;
            end
          end
          if (sync_m) q_nxt.rxc[`B_SINGLE_RECEIVE_ENABLE] = 1'b0;
        end
      endcase
    end
    // Transmitter; receive enables win in sync mode
    if (q_r.txc[`B_TRANSMITTER_ENABLE] && !(sync_m && rx_on) && tick_p) begin
      case (q_r.tst)
        SPCB_TI: if (q_r.tfull) begin
          q_nxt.tsh = {1'b1, q_r.txc[`B_NINTH_TRANSMIT_BIT], q_r.tbuf};
          q_nxt.tfull = 1'b0;
          q_nxt.tbrk = q_r.txc[`B_BRK] && !sync_m;
          q_nxt.tbit = 4'h0;
          q_nxt.tst = sync_m ? SPCB_TD : SPCB_TS;
          q_nxt.txc[`B_SHIFT_REGISTER_EMPTY_FLAG] = 1'b0;
        end
        SPCB_TS: begin
          q_nxt.txo = 1'b0;
          q_nxt.tst = SPCB_TD;
        end
        SPCB_TD: begin
          q_nxt.txo = q_r.tbrk ? 1'b0 : q_r.tsh[0];
          q_nxt.dto = q_r.tsh[0];
          q_nxt.tsh = {1'b1, q_r.tsh[9:1]};
          q_nxt.tbit = q_r.tbit + 4'h1;
          if (q_r.tbit == (q_r.txc[`B_TX9] ? 4'h8 : 4'h7)) q_nxt.tst = SPCB_TP;
        end
        default: begin
          q_nxt.txo = 1'b1;
          q_nxt.tst = SPCB_TI;
          q_nxt.txc[`B_SHIFT_REGISTER_EMPTY_FLAG] = 1'b1;
          q_nxt.txc[`B_BRK] = 1'b0;
        end
      endcase
    end
    // overrun cleared by clearing continuous enable, or by the port disable below; checked after the receiver
    if (!q_nxt.rxc[`B_CONTINUOUS_RECEIVE_ENABLE]) q_nxt.rxc[`B_OVERRUN_ERROR_FLAG] = 1'b0;
    if (sync_m && q_r.txc[`B_CLOCK_SOURCE_SELECT] && tick_p) q_nxt.cko = !q_r.cko;
    // port disabled holds receive and transmit state machines, buffer flags and status bits other than ABOV reset; baud timer keeps running
    if (!en) begin
      q_nxt.rst_s = SPCB_IDLE;
      q_nxt.tst = SPCB_TI;
      q_nxt.rfull = 1'b0;
      q_nxt.tfull = 1'b0;
      q_nxt.txc[`B_SHIFT_REGISTER_EMPTY_FLAG] = 1'b1;
      q_nxt.bdc[`B_IDLE] = 1'b1;
      q_nxt.rxc[2:0] = 3'h0;
      q_nxt.txo = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
      q_r.txc <= 8'h02;
      q_r.bdc <= 8'h40;
      q_r.txo <= 1'b1;
      q_r.rs <= 3'h7;
      q_r.rxl <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Pin outputs from flip-flops; async idle level and sync edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ck_o <= 1'b1;
      ck_oe_n <= 1'b1;
      rxd_o <= 1'b1;
      rxd_oe_n <= 1'b1;
    end else begin
      ck_o <= sync_m ? (q_nxt.cko ^ q_r.bdc[`B_TXP]) : (q_nxt.txo ^ q_r.bdc[`B_TXP]);
      ck_oe_n <= !(q_nxt.rxc[`B_PORT_ENABLE] && (!sync_m || q_r.txc[`B_CLOCK_SOURCE_SELECT]));
      rxd_o <= q_nxt.dto;
      rxd_oe_n <= !(q_nxt.rxc[`B_PORT_ENABLE] && sync_m && q_r.txc[`B_TRANSMITTER_ENABLE] && !rx_on);
    end
  end

  assign rdata = q_r.rdata;
  assign rx_flag = q_r.flag;
  assign baud_tick = q_r.tick;

  a_div_restart: assert property (@(posedge clk) disable iff (rst)
    wr && (addr == `SPCB_OFF_DLO) |=> q_r.cnt == 16'h0000) else $error("timer not restarted");
  a_shift_register_empty_flag_idle: assert property (@(posedge clk) disable iff (rst)
    (q_r.tst == SPCB_TI) && !q_r.tfull |-> q_r.txc[`B_SHIFT_REGISTER_EMPTY_FLAG]) else $error("empty flag wrong");
  a_overrun_error_flag_clear: assert property (@(posedge clk) disable iff (rst)
    !q_r.rxc[`B_CONTINUOUS_RECEIVE_ENABLE] |=> !q_r.rxc[`B_OVERRUN_ERROR_FLAG]) else $error("overrun not cleared");
  a_idle_flag: assert property (@(posedge clk) disable iff (rst)
    q_r.rst_s == SPCB_IDLE && !sync_m |-> q_r.bdc[`B_IDLE]) else $error("idle flag wrong");
  a_port_reset: assert property (@(posedge clk) disable iff (rst)
    !en |=> q_r.tst == SPCB_TI && !q_r.rfull) else $error("port not held");
  a_rd_data: assert property (@(posedge clk) disable iff (rst)
    rd && addr == `SPCB_OFF_DLO |=> rdata == $past(q_r.dlo)) else $error("read wrong");
  a_tick_rate: assert property (@(posedge clk) disable iff (rst)
    baud_tick |-> !$past(baud_tick)) else $error("tick back to back");
  a_sync_prio: assert property (@(posedge clk) disable iff (rst)
    sync_m && rx_on && q_r.tst == SPCB_TI |=> q_r.tst == SPCB_TI) else $error("tx ran");
  c_tx: cover property (@(posedge clk) q_r.tst == SPCB_TP);
  c_rx: cover property (@(posedge clk) q_r.rst_s == SPCB_STOP);
  c_ovr: cover property (@(posedge clk) q_r.rxc[`B_OVERRUN_ERROR_FLAG]);
endmodule
`default_nettype wire

// File: src/spcb_defs.svh
// Register offsets, field positions, write masks and constants of the serial port control block
`ifndef SPCB_DEFS_SVH
`define SPCB_DEFS_SVH
`define SPCB_AW 3
`define SPCB_OFF_TXC 3'h0
`define SPCB_OFF_RXC 3'h1
`define SPCB_OFF_BDC 3'h2
`define SPCB_OFF_DLO 3'h3
`define SPCB_OFF_DHI 3'h4
`define SPCB_OFF_RXB 3'h5
`define SPCB_OFF_TXB 3'h6
`define B_CLOCK_SOURCE_SELECT 7
`define B_TX9 6
`define B_TRANSMITTER_ENABLE 5
`define B_SYNC 4
`define B_BRK 3
`define B_HIGH_SPEED_BAUD_SELECT 2
`define B_SHIFT_REGISTER_EMPTY_FLAG 1
`define B_NINTH_TRANSMIT_BIT 0
`define B_PORT_ENABLE 7
`define B_RX9 6
`define B_SINGLE_RECEIVE_ENABLE 5
`define B_CONTINUOUS_RECEIVE_ENABLE 4
`define B_ADEN 3
`define B_FRAMING_ERROR_FLAG 2
`define B_OVERRUN_ERROR_FLAG 1
`define B_NINTH_RECEIVE_BIT 0
`define B_ABOV 7
`define B_IDLE 6
`define B_RXP 5
`define B_TXP 4
`define B_WIDE 3
`define B_WUE 1
`define B_ABD 0
`define SPCB_TXC_WMASK 8'hfd
`define SPCB_RXC_WMASK 8'hf8
`define SPCB_BDC_WMASK 8'h3b
`define SPCB_MUL_A8L 8'h40
`define SPCB_MUL_A8H 8'h10
`define SPCB_MUL_A16L 8'h10
`define SPCB_MUL_A16H 8'h04
`define SPCB_MUL_SYN 8'h04
`endif

// File: src/spcb_pkg.sv
// Types for the serial port control block
package spcb_pkg;
  typedef enum logic [1:0] {
    SPCB_IDLE  = 2'b00,
    SPCB_START = 2'b01,
    SPCB_DATA  = 2'b10,
    SPCB_STOP  = 2'b11
  } spcb_st_e;
  typedef enum logic [1:0] {
    SPCB_TI = 2'b00,
    SPCB_TS = 2'b01,
    SPCB_TD = 2'b10,
    SPCB_TP = 2'b11
  } spcb_tst_e;
endpackage

// File: bench/spcb_remote.sv
// Remote asynchronous station: frame sender and transmit line capture
`timescale 1ns/1ps
`default_nettype none
module spcb_remote #(
  parameter int BIT = 16
) (
  input  wire logic       clk,    // System clock
  output logic            line_o, // Drives the receive pin
  input  wire logic       line_i, // Transmit line of the port
  output logic [8:0]      cap,    // Nine samples after a start bit
  output logic [7:0]      n_cap   // Captured frame count
);
  initial begin
    line_o = 1'b1;
    cap = '0;
    n_cap = '0;
  end
  // Static line level, used for idle, polarity and wake edges
  task automatic lvl(input logic b);
    @(posedge clk);
    line_o <= b;
  endtask
  // Start, data LSB first, stop; each bit held one bit time
  task automatic send(input logic [8:0] d, input int nb, input logic stp, input logic inv);
    logic [10:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i+1] = d[i];
    f[nb+1] = stp;
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge clk);
      line_o <= f[i] ^ inv;
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk);
    line_o <= ~inv;
  endtask
  // Mid-bit sampling; ninth sample is the stop bit in 8-bit frames
  always begin
    @(negedge line_i);
    repeat (BIT + BIT / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      cap[i] <= line_i;
      repeat (BIT) @(posedge clk);
    end
    n_cap <= n_cap + 8'h01;
  end
endmodule
`default_nettype wire

// File: bench/tb_serial_port_control_baud.sv
// Register-level testbench of the serial port control block
`include "spcb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_control_baud;
  localparam int BIT = 16;
  logic       clk, rst, wr, rd, rxd_o, rxd_oe_n, ck_o, ck_oe_n, rx_flag, baud_tick, line, s;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v, n_cap, n0;
  logic [8:0] cap;
  wire        rxd_pin;
  wire        ck_pin;
  int         n_errors, tests_run, cyc, c1, c2;
  logic [7:0] bt_txc [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h94, 8'h04};
  logic [7:0] bt_bdc [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00};
  logic [7:0] bt_lo [6] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h02, 8'h00};
  logic [7:0] bt_hi [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01};
  int         bt_p [6] = '{192, 48, 48, 1028, 12, 16};
  // Pin levels; clock pin pulled up when nobody drives it
  assign rxd_pin = (rxd_oe_n === 1'b0) ? rxd_o : line;
  assign ck_pin  = (ck_oe_n === 1'b0) ? ck_o : 1'b1;
  spcb_top #(.ABD_MAX(50)) DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n),
    .ck_i(ck_pin), .ck_o(ck_o), .ck_oe_n(ck_oe_n), .rx_flag(rx_flag), .baud_tick(baud_tick));
  spcb_remote #(.BIT(BIT)) remote (.clk(clk), .line_o(line), .line_i(ck_pin), .cap(cap),
    .n_cap(n_cap));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Register bus cycles; read data stand only in the cycle after the strobe
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    chk(nm, {8'h00, v}, {8'h00, e});
  endtask
  // Bounded waits for the receive flag and for the next baud tick
  task automatic wflag(output logic f);
    f = 1'b0;
    repeat (3 * BIT) begin
      @(negedge clk);
      if (rx_flag === 1'b1) f = 1'b1;
    end
  endtask
  task automatic tgap(output int n);
    n = 1;
    @(negedge clk);
    while (baud_tick !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic txcap(input logic [7:0] d, input logic [8:0] e);
    n0 = n_cap;
    wreg(`SPCB_OFF_TXB, d);
    repeat (20 * BIT) if (n_cap == n0) @(negedge clk);
    chk("txframe", {7'h00, cap}, {7'h00, e});
  endtask
  initial begin
    {rst, wr, rd, addr, wdata, n_errors, tests_run, cyc} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("pins_free", {15'h0, ck_oe_n}, 16'h1);
    rchk("txc_rst", `SPCB_OFF_TXC, 8'h02);
    rchk("rxc_rst", `SPCB_OFF_RXC, 8'h00);
    rchk("bdc_rst", `SPCB_OFF_BDC, 8'h40);
    rchk("unmapped", 3'h7, 8'h00);
    wreg(`SPCB_OFF_TXC, 8'h00);
    rchk("txc_ro", `SPCB_OFF_TXC, 8'h02);
    wreg(`SPCB_OFF_RXC, 8'h07);
    rchk("rxc_ro", `SPCB_OFF_RXC, 8'h00);
    wreg(`SPCB_OFF_BDC, 8'hc4);
    rchk("bdc_ro", `SPCB_OFF_BDC, 8'h40);
    wreg(`SPCB_OFF_RXC, 8'h80);
    // Baud periods per mode; a divisor write restarts the timer
    for (int i = 0; i < 6; i++) begin
      wreg(`SPCB_OFF_TXC, bt_txc[i]);
      wreg(`SPCB_OFF_BDC, bt_bdc[i]);
      wreg(`SPCB_OFF_DHI, bt_hi[i]);
      wreg(`SPCB_OFF_DLO, bt_lo[i]);
      tgap(c1);
      tgap(c2);
      chk("period", c2[15:0], bt_p[i][15:0]);
      chk("restart", {15'h0, c1 >= bt_p[i] - 3 && c1 <= bt_p[i] + 2}, 16'h1);
      if (i == 4) chk("master_ck", {15'h0, ck_oe_n}, 16'h0);
    end
    // Async link at sixteen clocks per bit
    wreg(`SPCB_OFF_BDC, 8'h08);
    wreg(`SPCB_OFF_DHI, 8'h00);
    wreg(`SPCB_OFF_DLO, 8'h03);
    wreg(`SPCB_OFF_TXC, 8'h24);
    wreg(`SPCB_OFF_RXC, 8'h90);
    repeat (200) @(posedge clk);
    chk("pins_taken", {15'h0, ck_oe_n}, 16'h0);
    fork
      remote.send(9'h0a5, 8, 1'b1, 1'b0);
      begin
        repeat (3 * BIT) @(posedge clk);
        rchk("rx_busy", `SPCB_OFF_BDC, 8'h08);
      end
    join
    wflag(s);
    chk("flag", {15'h0, s}, 16'h1);
    rchk("rxc_ok", `SPCB_OFF_RXC, 8'h90);
    rchk("rxb", `SPCB_OFF_RXB, 8'ha5);
    @(negedge clk);
    chk("flag_clr", {15'h0, rx_flag}, 16'h0);
    wreg(`SPCB_OFF_RXC, 8'hd0);
    remote.send(9'h13c, 9, 1'b1, 1'b0);
    wflag(s);
    rchk("ninth", `SPCB_OFF_RXC, 8'hd1);
    rchk("rxb9", `SPCB_OFF_RXB, 8'h3c);
    wreg(`SPCB_OFF_RXC, 8'hd8);
    remote.send(9'h055, 9, 1'b1, 1'b0);
    wflag(s);
    chk("data_skip", {15'h0, s}, 16'h0);
    remote.send(9'h166, 9, 1'b1, 1'b0);
    wflag(s);
    chk("addr_take", {15'h0, s}, 16'h1);
    rchk("rxb_adr", `SPCB_OFF_RXB, 8'h66);
    wreg(`SPCB_OFF_RXC, 8'h90);
    remote.send(9'h00f, 8, 1'b0, 1'b0);
    wflag(s);
    rchk("framing_error_flag", `SPCB_OFF_RXC, 8'h94);
    rchk("rxb_fe", `SPCB_OFF_RXB, 8'h0f);
    remote.send(9'h011, 8, 1'b1, 1'b0);
    remote.send(9'h022, 8, 1'b1, 1'b0);
    wflag(s);
    rchk("overrun_error_flag", `SPCB_OFF_RXC, 8'h92);
    wreg(`SPCB_OFF_RXC, 8'h80);
    rchk("overrun_error_flag_clr", `SPCB_OFF_RXC, 8'h80);
    rchk("rxb_head", `SPCB_OFF_RXB, 8'h11);
    wreg(`SPCB_OFF_RXC, 8'h90);
    // Transmit, 8-bit then 9-bit with the ninth bit clear
    fork
      txcap(8'hc3, 9'h1c3);
      begin
        repeat (3 * BIT) @(posedge clk);
        rchk("tsr_full", `SPCB_OFF_TXC, 8'h24);
      end
    join
    repeat (2 * BIT) @(posedge clk);
    rchk("tsr_empty", `SPCB_OFF_TXC, 8'h26);
    wreg(`SPCB_OFF_TXC, 8'h64);
    txcap(8'h3c, 9'h03c);
    repeat (2 * BIT) @(posedge clk);
    wreg(`SPCB_OFF_TXC, 8'h2c);
    wreg(`SPCB_OFF_TXB, 8'h00);
    repeat (3 * BIT) @(posedge clk);
    rchk("brk_busy", `SPCB_OFF_TXC, 8'h2c);
    repeat (12 * BIT) @(posedge clk);
    rchk("brk_done", `SPCB_OFF_TXC, 8'h26);
    // Wake-up on a falling edge, self-clear on the rising edge
    wreg(`SPCB_OFF_BDC, 8'h0a);
    remote.lvl(1'b0);
    wflag(s);
    chk("wake_flag", {15'h0, s}, 16'h1);
    remote.lvl(1'b1);
    repeat (3 * BIT) @(posedge clk);
    rchk("wake_clr", `SPCB_OFF_BDC, 8'h48);
    // Inverted line; receiver off while the idle level flips
    wreg(`SPCB_OFF_RXC, 8'h80);
    wreg(`SPCB_OFF_BDC, 8'h28);
    remote.lvl(1'b0);
    repeat (2 * BIT) @(posedge clk);
    wreg(`SPCB_OFF_RXC, 8'h90);
    remote.send(9'h05a, 8, 1'b1, 1'b1);
    wflag(s);
    rchk("rx_inv", `SPCB_OFF_RXB, 8'h5a);
    // Receiver must be idle before the line setup changes
    rchk("rx_idle", `SPCB_OFF_BDC, 8'h68);
    wreg(`SPCB_OFF_BDC, 8'h18);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("tx_idle_low", {15'h0, ck_o}, 16'h0);
    summarize();
  end
endmodule
`default_nettype wire
